/* rtl/div_len.sv */
`timescale 1ns/1ns
`default_nettype none
module div_len
  import lat_pkg::*;
(
  // Operand.
  input wire logic [31:0] i_divisor,
  input wire op_size_e i_size,
  input wire logic i_signed,
  // Count.
  output logic [7:0] o_cycles
);
  logic [5:0] width;
  logic [5:0] lead;
  logic [7:0] span;
  logic [7:0] base;
  logic [7:0] extra;
  logic [15:0] prod;

  // Data-dependent count: wide divisors finish early, since fewer
  // quotient bits remain to resolve.
  always_comb begin
    lead = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (i_divisor[i]) begin
        lead = 6'(i + 1);
      end
    end
    case (i_size)
      SZ_BYTE: begin
        width = 6'h08;
        span = CYC_BYTE_SPAN;
      end
      SZ_WORD: begin
        width = 6'h10;
        span = CYC_WORD_SPAN;
      end
      default: begin
        width = 6'h20;
        span = CYC_DWORD_SPAN;
      end
    endcase
    if (lead > width) begin
      lead = width;
    end
    // bounded by span
    // The product needs 16 bits: a zero dword divisor reaches 32 times 28.
    prod = 16'(width - lead) * 16'(span);
    extra = 8'(prod / 16'(width));
    if (!i_signed) begin
      base = CYC_UDIV_MIN;
    end else if (i_size == SZ_DWORD) begin
      base = CYC_SDIV_D_MIN;
    end else begin
      base = CYC_SDIV_MIN;
    end
    o_cycles = base + extra;
  end
endmodule : div_len
`default_nettype wire

/* rtl/instr_latency_table_subset.sv */
// Notes on behaviour
// - Decimal adjust after add, opcode 27, takes 6 clocks and writes flags.
// - Decimal adjust after subtract, opcode 2F, takes 6 clocks, writes flags.
// - Word to dword extend, opcode 98, takes 2 clocks and keeps flags.
// - Frame entry takes 10 at level 0, 13 at level 1, else 10+L*3 clocks.
// - Unsigned divide takes 13-17, 13-25 or 13-41 clocks by divisor size.
// - Signed divide takes 16-20, 16-28 or 17-45 clocks by divisor size.
// - Compare and swap, both forms, takes 11 clocks and writes flags.
// - Decrement, both forms, takes 1 clock, keeps carry, writes other flags.
`timescale 1ns/1ns
`default_nettype none
module instr_latency_table_subset
  import lat_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // From fetch.
  input wire logic i_valid,
  input wire fetch_s i_fetch,
  output logic o_ready,
  // To execution.
  output logic o_valid,
  output result_s o_result,
  output logic o_busy
);
  result_s dec;
  result_s result;
  result_s next_result;
  logic valid;
  logic next_valid;
  logic [7:0] count;
  logic [7:0] next_count;
  logic [7:0] div_cycles;
  op_size_e size;
  logic [2:0] sub;

  assign sub = i_fetch.modrm[5:3];
  always_comb begin
    if (!i_fetch.opcode[0]) begin
      size = SZ_BYTE;
    end else if (i_fetch.op32) begin
      size = SZ_DWORD;
    end else begin
      size = SZ_WORD;
    end
  end

  div_len div_len_inst (
    .i_divisor(i_fetch.divisor),
    .i_size(size),
    .i_signed(sub == REG_SDIV),
    .o_cycles(div_cycles)
  );

  always_comb begin
    dec = '{kind: K_NONE, flags_written: 1'b0, carry_kept: 1'b0,
      cycles: CYC_DEC};
    case (i_fetch.opcode)
      OP_DEC_ADJ_ADD: begin
        dec = '{K_ADJ_ADD, 1'b1, 1'b0, CYC_ADJUST};
      end
      OP_DEC_ADJ_SUB: begin
        dec = '{K_ADJ_SUB, 1'b1, 1'b0, CYC_ADJUST};
      end
      OP_WORD_EXT: begin
        dec = '{K_EXTEND, 1'b0, 1'b0, CYC_EXTEND};
      end
      OP_FRAME_ENTER: begin
        dec.kind = K_ENTER;
        if (i_fetch.level == 5'h00) begin
          dec.cycles = CYC_ENTER_BASE;
        end else if (i_fetch.level == 5'h01) begin
          dec.cycles = CYC_ENTER_L1;
        end else begin
          dec.cycles = CYC_ENTER_BASE
            + 8'({3'h0, i_fetch.level} * CYC_ENTER_STEP);
        end
      end
      OP_TWO_BYTE: begin
        if (i_fetch.second == OP_CMP_SWAP_B
            || i_fetch.second == OP_CMP_SWAP_W) begin
          dec = '{K_CMP_SWAP, 1'b1, 1'b0, CYC_CMP_SWAP};
        end
      end
      OP_GRP3_B, OP_GRP3_W: begin
        if (sub == REG_UDIV || sub == REG_SDIV) begin
          dec.kind = (sub == REG_UDIV) ? K_UDIV : K_SDIV;
          dec.flags_written = 1'b1;
          dec.cycles = div_cycles;
        end
      end
      OP_GRP45_B, OP_GRP45_W: begin
        if (sub == REG_DEC) begin
          dec = '{K_DEC, 1'b1, 1'b1, CYC_DEC};
        end
      end
      default: begin
        if (i_fetch.opcode[7:3] == OP_DEC_SHORT_HI) begin
          dec = '{K_DEC, 1'b1, 1'b1, CYC_DEC};
        end
      end
    endcase
  end

  // A new instruction is taken only when the previous one has run out,
  // so execution never sees overlapping latencies.
  assign o_ready = (count == 8'h00);
  assign o_busy = !o_ready;

  always_comb begin
    next_valid = 1'b0;
    next_result = result;
    next_count = count;
    if (count != 8'h00) begin
      next_count = count - 8'h01;
    end
    if (i_valid && o_ready) begin
      next_valid = 1'b1;
      next_result = dec;
      next_count = dec.cycles - 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      valid <= 1'b0;
      result <= '{K_NONE, 1'b0, 1'b0, 8'h00};
      count <= 8'h00;
    end else begin
      valid <= next_valid;
      result <= next_result;
      count <= next_count;
    end
  end

  assign o_valid = valid;
  assign o_result = result;

  adj_add_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_valid && o_ready && i_fetch.opcode == OP_DEC_ADJ_ADD
    |=> o_result.cycles == 8'h06 && o_result.flags_written)
    else $error("adjust add count wrong");
  adj_sub_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_valid && o_ready && i_fetch.opcode == OP_DEC_ADJ_SUB
    |=> o_busy [*5] ##1 o_ready)
    else $error("adjust subtract busy span wrong");
  extend_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_valid && o_ready && i_fetch.opcode == OP_WORD_EXT
    |=> o_busy ##1 o_ready && !o_result.flags_written)
    else $error("extend latency wrong");
  enter_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_valid && o_result.kind == K_ENTER
    |-> o_result.cycles == (($past(i_fetch.level) == 5'h01) ? 8'h0D
      : 8'(8'h0A + 8'h03 * $past(i_fetch.level))))
    else $error("enter count wrong");
  udiv_range_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_valid && o_result.kind == K_UDIV |-> o_result.cycles >= 8'h0D
    && o_result.cycles <= 8'h29)
    else $error("unsigned divide out of range");
  sdiv_range_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_valid && o_result.kind == K_SDIV |-> o_result.cycles >= 8'h10
    && o_result.cycles <= 8'h2D)
    else $error("signed divide out of range");
  swap_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_valid && o_result.kind == K_CMP_SWAP
    |-> o_result.cycles == 8'h0B ##10 o_ready)
    else $error("compare swap latency wrong");
  dec_one_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_valid && o_result.kind == K_DEC
    |-> o_ready && o_result.carry_kept)
    else $error("decrement not one clock");
  div_byte_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_valid && o_ready && i_fetch.opcode == OP_GRP3_B
    && (sub == REG_UDIV || sub == REG_SDIV)
    |=> o_result.cycles <= 8'h14)
    else $error("byte divide too long");
  udiv_word_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_valid && o_ready && i_fetch.opcode == OP_GRP3_W && !i_fetch.op32
    && sub == REG_UDIV |=> o_result.cycles <= 8'h19)
    else $error("word divide too long");
  sdiv_long_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_valid && o_ready && i_fetch.opcode == OP_GRP3_W && i_fetch.op32
    && sub == REG_SDIV |=> o_result.cycles >= 8'h11)
    else $error("signed dword divide too short");
  swap_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_valid && o_result.kind == K_CMP_SWAP |-> o_result.flags_written)
    else $error("compare swap flags not written");
  dec_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_valid && o_result.kind == K_DEC |-> o_result.flags_written)
    else $error("decrement flags not written");

  div_c: cover property (@(posedge i_clk) o_valid && o_result.kind == K_SDIV);
  enter_c: cover property (@(posedge i_clk)
    o_valid && o_result.kind == K_ENTER && o_result.cycles > 8'h0D);
  back_c: cover property (@(posedge i_clk) o_valid ##1 o_valid);
  swap_c: cover property (@(posedge i_clk)
    o_valid && o_result.kind == K_CMP_SWAP);
  udiv_c: cover property (@(posedge i_clk)
    o_valid && o_result.kind == K_UDIV && o_result.cycles > 8'h19);
endmodule : instr_latency_table_subset
`default_nettype wire

/* rtl/lat_pkg.sv */
package lat_pkg;
  // Opcode bytes, the short decrement's top opcode bits, and ModRM reg values.
  localparam logic [7:0] OP_DEC_ADJ_ADD = 8'h27;
  localparam logic [7:0] OP_DEC_ADJ_SUB = 8'h2F;
  localparam logic [7:0] OP_WORD_EXT = 8'h98;
  localparam logic [7:0] OP_FRAME_ENTER = 8'hC8;
  localparam logic [7:0] OP_TWO_BYTE = 8'h0F;
  localparam logic [7:0] OP_CMP_SWAP_B = 8'hB0;
  localparam logic [7:0] OP_CMP_SWAP_W = 8'hB1;
  localparam logic [7:0] OP_GRP3_B = 8'hF6;
  localparam logic [7:0] OP_GRP3_W = 8'hF7;
  localparam logic [7:0] OP_GRP45_B = 8'hFE;
  localparam logic [7:0] OP_GRP45_W = 8'hFF;
  localparam logic [4:0] OP_DEC_SHORT_HI = 5'h09;
  localparam logic [2:0] REG_DEC = 3'h1;
  localparam logic [2:0] REG_UDIV = 3'h6;
  localparam logic [2:0] REG_SDIV = 3'h7;
  // Cycle counts.
  localparam logic [7:0] CYC_ADJUST = 8'h06;
  localparam logic [7:0] CYC_EXTEND = 8'h02;
  localparam logic [7:0] CYC_ENTER_BASE = 8'h0A;
  localparam logic [7:0] CYC_ENTER_L1 = 8'h0D;
  localparam logic [7:0] CYC_ENTER_STEP = 8'h03;
  localparam logic [7:0] CYC_CMP_SWAP = 8'h0B;
  localparam logic [7:0] CYC_DEC = 8'h01;
  localparam logic [7:0] CYC_UDIV_MIN = 8'h0D;
  localparam logic [7:0] CYC_SDIV_MIN = 8'h10;
  localparam logic [7:0] CYC_SDIV_D_MIN = 8'h11;
  localparam logic [7:0] CYC_BYTE_SPAN = 8'h04;
  localparam logic [7:0] CYC_WORD_SPAN = 8'h0C;
  localparam logic [7:0] CYC_DWORD_SPAN = 8'h1C;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_DWORD = 2'b10
  } op_size_e;

  typedef enum logic [3:0] {
    K_NONE = 4'h0,
    K_ADJ_ADD = 4'h1,
    K_ADJ_SUB = 4'h2,
    K_EXTEND = 4'h3,
    K_ENTER = 4'h4,
    K_UDIV = 4'h5,
    K_SDIV = 4'h6,
    K_CMP_SWAP = 4'h7,
    K_DEC = 4'h8
  } instr_kind_e;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] second;
    logic [7:0] modrm;
    logic [4:0] level;
    logic op32;
    logic [31:0] divisor;
  } fetch_s;

  typedef struct packed {
    instr_kind_e kind;
    logic flags_written;
    logic carry_kept;
    logic [7:0] cycles;
  } result_s;
endpackage : lat_pkg

/* tb/fetch_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fetch_model
  import lat_pkg::*;
(
  // Clock and handshake.
  input wire logic i_clk,
  input wire logic i_ready,
  // To the block.
  output logic o_valid,
  output fetch_s o_fetch
);
  initial begin
    o_valid = 1'b0;
    o_fetch = '0;
  end
  // Called at a falling edge; the offer stays up so that 1-cycle ops run
  // back to back, and a later call or idle replaces it.
  task send(input fetch_s f);
    o_valid = 1'b1;
    o_fetch = f;
    while (i_ready !== 1'b1) @(negedge i_clk);
    @(negedge i_clk);
  endtask : send
  // A released bus shows the inverse, not a stale copy.
  task idle;
    o_valid = 1'b0;
    o_fetch = ~o_fetch;
  endtask : idle
endmodule : fetch_model
`default_nettype wire

/* tb/instr_latency_table_subset_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module instr_latency_table_subset_bench;
  import lat_pkg::*;
  typedef struct packed {
    instr_kind_e kind;
    logic fon;
    logic fw;
    logic [1:0] ck;
    logic [7:0] lo;
    logic [7:0] hi;
  } exp_s;
  logic i_clk, i_rst_n, i_valid, o_ready, o_valid, o_busy;
  fetch_s i_fetch;
  result_s o_result;
  exp_s q[$];
  exp_s e;
  int n_errors = 0, tests_run = 0, seed = 70793, n, i, s, z, j, wd, sp;
  logic [31:0] d, m;
  logic [7:0] lo, hi;

  instr_latency_table_subset instr_latency_table_subset_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
    .i_fetch(i_fetch), .o_ready(o_ready), .o_valid(o_valid),
    .o_result(o_result), .o_busy(o_busy));
  fetch_model fetch_model_inst (.i_clk(i_clk), .i_ready(o_ready),
    .o_valid(i_valid), .o_fetch(i_fetch));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task cmp_val(input string nm, input logic [7:0] ex, input logic [7:0] sn);
    tests_run++;
    if (sn !== ex) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, sn);
    end
  endtask : cmp_val

  task cmp_rng(input string nm, input logic [7:0] l, h, sn);
    tests_run++;
    if (!((sn >= l) === 1'b1 && (sn <= h) === 1'b1)) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0h", nm, l, h, sn);
    end
  endtask : cmp_rng

  task end_of_test;
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task go(input instr_kind_e k, input logic fon, fw, input logic [1:0] ck,
          input logic [7:0] l, h, op, sec, mr, input logic [4:0] lv,
          input logic w, input logic [31:0] dv);
    q.push_back('{k, fon, fw, ck, l, h});
    fetch_model_inst.send('{op, sec, mr, lv, w, dv});
  endtask : go

  // Results are paired with the oldest note; busy must span cycles-1.
  initial forever begin
    @(negedge i_clk);
    if (o_valid === 1'b1) begin
      if (q.size() == 0) begin
        cmp_val("unexpected take", 8'h00, 8'h01);
      end else begin
        e = q.pop_front();
        cmp_val("kind", 8'(e.kind), 8'(o_result.kind));
        cmp_rng("cycles", e.lo, e.hi, o_result.cycles);
        if (e.fon) cmp_val("flags", 8'(e.fw), 8'(o_result.flags_written));
        if (e.ck[1]) cmp_val("carry", 8'(e.ck[0]), 8'(o_result.carry_kept));
        n = 0;
        while (o_busy === 1'b1 && n < 200) begin
          n++;
          @(negedge i_clk);
        end
        cmp_rng("busy", e.lo - 8'h01, e.hi - 8'h01, n[7:0]);
      end
    end
  end

  initial begin
    #(50 * 20000);
    n_errors++;
    end_of_test();
  end

  initial begin
    i_rst_n = 1'b0;
    repeat (20) @(negedge i_clk);
    cmp_val("idle ready", 8'h01, 8'(o_ready));
    i_rst_n = 1'b1;
    go(K_ADJ_ADD, 1, 1, 2'b10, 6, 6, OP_DEC_ADJ_ADD, 0, 0, 0, 0, 0);
    go(K_ADJ_SUB, 1, 1, 2'b10, 6, 6, OP_DEC_ADJ_SUB, 0, 0, 0, 0, 0);
    go(K_EXTEND, 1, 0, 2'b00, 2, 2, OP_WORD_EXT, 0, 0, 0, 1, 0);
    for (i = 0; i < 4; i++)
      go(K_CMP_SWAP, 1, 1, 2'b10, 11, 11, OP_TWO_BYTE,
         i[0] ? OP_CMP_SWAP_W : OP_CMP_SWAP_B, i[1] ? 8'hC0 : 8'h00,
         0, i[0], 0);
    go(K_DEC, 1, 1, 2'b11, 1, 1, OP_GRP45_B, 0, 8'hC8, 0, 0, 0);
    go(K_DEC, 1, 1, 2'b11, 1, 1, OP_GRP45_W, 0, 8'h0A, 0, 1, 0);
    for (i = 0; i < 8; i++)
      go(K_DEC, 1, 1, 2'b11, 1, 1, 8'h48 + 8'(i), 0, 0, 0, 1, 0);
    go(K_NONE, 0, 0, 2'b00, 1, 1, 8'hF4, 0, 0, 0, 0, 0);
    for (i = 0; i < 32; i++) begin
      lo = (i == 0) ? 8'h0A : (i == 1) ? 8'h0D : 8'(10 + 3 * i);
      go(K_ENTER, 0, 0, 2'b00, lo, lo, OP_FRAME_ENTER, 0, 0, 5'(i), 1, 0);
    end
    for (s = 0; s < 2; s++)
      for (z = 0; z < 3; z++)
        for (j = 0; j < 4; j++) begin
          m = (z == 0) ? 32'h0000_00FF
            : (z == 1) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
          d = (j == 0) ? 32'h1 : (j == 1) ? m : ($random(seed) & m);
          if (d == 0) d = 32'h1;
          wd = 8 << z;
          sp = (z == 0) ? CYC_BYTE_SPAN : (z == 1) ? CYC_WORD_SPAN
            : CYC_DWORD_SPAN;
          lo = s ? ((z == 2) ? 8'h11 : 8'h10) : 8'h0D;
          hi = lo + 8'(sp);
          // A one-bit divisor runs nearly the whole span, a full-width
          // divisor none of it, so both ends are pinned exactly.
          if (j == 0) lo = lo + 8'((wd - 1) * sp / wd);
          if (j < 2) hi = lo;
          go(s ? K_SDIV : K_UDIV, 0, 0, 2'b00, lo, hi,
             (z == 0) ? OP_GRP3_B : OP_GRP3_W, 0, s ? 8'hF8 : 8'hF0,
             0, z == 2, d);
        end
    fetch_model_inst.idle();
    repeat (60) @(negedge i_clk);
    cmp_val("pending", 8'h00, 8'(q.size()));
    end_of_test();
  end
endmodule : instr_latency_table_subset_bench
`default_nettype wire
